/* hdl/ipcg_pkg.sv */
`default_nettype none
package ipcg_pkg;
	// one sys_clock_out period spans this many clk_sys_i cycles
	localparam int unsigned OUT_CLK_DIV = 2;
	// timing in sys_clock_out cycles or half cycles, as the behaviour is stated
	localparam int unsigned INT_RESTART_HALF = 3;
	localparam int unsigned NMI_RESTART_OUTCLK = 2;
	localparam int unsigned VECTOR_OUTCLK = 6;
	localparam int unsigned DMA_START_FALLS = 3;
	localparam int unsigned INT_RESTART_CYC = (INT_RESTART_HALF * OUT_CLK_DIV + 1) / 2;
	localparam int unsigned NMI_RESTART_CYC = NMI_RESTART_OUTCLK * OUT_CLK_DIV;
	localparam int unsigned VECTOR_CYC = VECTOR_OUTCLK * OUT_CLK_DIV;
	localparam int unsigned WAKE_CNT_W = 4;
	localparam int unsigned BUS_CNT_W = 2;
	// power mode field
	localparam int unsigned PWR_W = 2;
	localparam logic [1:0] PWR_RESET = 2'h0;
	localparam logic [1:0] PWR_PDOWN = 2'h1;
	localparam logic [1:0] PWR_IDLE = 2'h2;
	localparam int unsigned PIN_SYNC_STAGES = 3;
	localparam int unsigned PIN_DMA = 0;
	localparam int unsigned PIN_HOLD = 1;
	localparam int unsigned PIN_NMI = 2;

	typedef enum logic [1:0] {IPCG_ACTIVE, IPCG_IDLE, IPCG_PDOWN} ipcg_mode_e;

	typedef struct packed {
		logic core;
		logic periph;
		logic osc;
	} ipcg_clk_s;

	typedef struct packed {
		logic go;
		logic refresh;
	} ipcg_bus_s;
endpackage
`default_nettype wire

/* hdl/ipcg_gate.sv */
`default_nettype none
module ipcg_gate (
	input wire logic clk_sys_i,
	input wire logic rst_i,
	input wire logic pwr_wr_i,
	input wire logic [ipcg_pkg::PWR_W-1:0] pwr_data_i,
	input wire logic halt_i,
	input wire logic refresh_zero_i,
	input wire logic dma_req_i,
	input wire logic hold_i,
	input wire logic nmi_i,
	input wire logic int_resolved_i,
	input wire logic bus_done_i,
	output ipcg_pkg::ipcg_clk_s clk_en_o,
	output logic sys_clock_out_o,
	output logic bus_grant_out_o,
	output ipcg_pkg::ipcg_bus_s bus_o,
	output logic vector_start_o,
	output logic vector_nmi_o,
	output logic [ipcg_pkg::PWR_W-1:0] power_control_reg_o,
	output ipcg_pkg::ipcg_mode_e mode_o
);
	import ipcg_pkg::*;

	typedef enum logic [2:0] {B_OFF, B_WAIT, B_TIDLE, B_RUN, B_TAIL} ipcg_bus_e;
	typedef enum logic [2:0] {H_OFF, H_WAIT, H_CORE, H_GRANT, H_REL} ipcg_hold_e;
	typedef enum logic [1:0] {W_OFF, W_RESTART, W_VECTOR} ipcg_wake_e;

	logic [PWR_W-1:0] power_control_reg;
	ipcg_mode_e mode;
	logic phase;
	logic fall;
	logic [2:0] pin_s1, pin_s2, pin_s3;
	logic [2:0] pin_lvl;
	logic nmi_prev;
	logic nmi_rise;
	logic ref_pend;
	ipcg_bus_e bst;
	logic [BUS_CNT_W-1:0] bcnt;
	logic bus_refresh;
	logic bus_go;
	ipcg_hold_e hst;
	ipcg_wake_e wst;
	logic [WAKE_CNT_W-1:0] wcnt;
	logic wake_nmi;
	logic wake_now;
	logic waking;
	logic core_en;
	logic in_idle;

	assign in_idle = (mode == IPCG_IDLE);
	assign fall = phase;
	assign waking = (mode != IPCG_ACTIVE) && (wst == W_OFF) && (nmi_rise || int_resolved_i);
	assign wake_now = (wst == W_RESTART) && (wcnt == '0);

	// clock output divider; frozen high in powerdown
	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			phase <= 1'b0;
		end else if (mode == IPCG_PDOWN) begin
			phase <= 1'b1;
		end else begin
			phase <= ~phase;
		end
	end

	// asynchronous pins: three stages, change accepted when stages two and three agree
	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			pin_s1 <= 3'h0;
			pin_s2 <= 3'h0;
			pin_s3 <= 3'h0;
			pin_lvl <= 3'h0;
			nmi_prev <= 1'b0;
		end else begin
			pin_s1 <= {nmi_i, hold_i, dma_req_i};
			pin_s2 <= pin_s1;
			pin_s3 <= pin_s2;
			for (int i = 0; i < PIN_SYNC_STAGES; i++) begin
				if (pin_s2[i] == pin_s3[i]) begin
					pin_lvl[i] <= pin_s3[i];
				end
			end
			nmi_prev <= pin_lvl[PIN_NMI];
		end
	end
	assign nmi_rise = pin_lvl[PIN_NMI] && !nmi_prev;

	// power control setting: only reset or a software write changes it
	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			power_control_reg <= PWR_RESET;
		end else if (pwr_wr_i) begin
			power_control_reg <= pwr_data_i;
		end
	end

	// mode: entered at halt, left by a finished wake restart
	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			mode <= IPCG_ACTIVE;
		end else if (wake_now) begin
			mode <= IPCG_ACTIVE;
		end else if (mode == IPCG_ACTIVE && halt_i) begin
			unique case (power_control_reg)
				PWR_IDLE: mode <= IPCG_IDLE;
				PWR_PDOWN: mode <= IPCG_PDOWN;
				default: mode <= IPCG_ACTIVE;
			endcase
		end
	end

	// interrupt and NMI wake sequencing; NMI skips the resolution delay
	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			wst <= W_OFF;
			wcnt <= '0;
			wake_nmi <= 1'b0;
		end else begin
			unique case (wst)
				W_OFF: begin
					if (waking) begin
						wst <= W_RESTART;
						wake_nmi <= nmi_rise;
						wcnt <= nmi_rise ? WAKE_CNT_W'(NMI_RESTART_CYC - 1)
							: WAKE_CNT_W'(INT_RESTART_CYC - 1);
					end
				end
				W_RESTART: begin
					if (wcnt == '0) begin
						wst <= W_VECTOR;
						wcnt <= WAKE_CNT_W'(VECTOR_CYC - 1);
					end else begin
						wcnt <= wcnt - 1'b1;
					end
				end
				W_VECTOR: begin
					if (wcnt == '0) begin
						wst <= W_OFF;
					end else begin
						wcnt <= wcnt - 1'b1;
					end
				end
				default: wst <= W_OFF;
			endcase
		end
	end
	assign vector_start_o = (wst == W_VECTOR) && (wcnt == '0);
	assign vector_nmi_o = wake_nmi;

	// refresh request latch; a new zero crossing wins over the clear
	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			ref_pend <= 1'b0;
		end else if (refresh_zero_i && mode != IPCG_PDOWN) begin
			ref_pend <= 1'b1;
		end else if (bus_go && bus_refresh) begin
			ref_pend <= 1'b0;
		end
	end

	// idle bus engine: core clock for one refresh or DMA cycle at a time
	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			bst <= B_OFF;
			bcnt <= '0;
			bus_refresh <= 1'b0;
			bus_go <= 1'b0;
		end else begin
			bus_go <= 1'b0;
			unique case (bst)
				B_OFF: begin
					if (in_idle && fall && ref_pend) begin
						bst <= B_TIDLE;
					end else if (in_idle && fall && pin_lvl[PIN_DMA]) begin
						bst <= B_WAIT;
						bcnt <= BUS_CNT_W'(DMA_START_FALLS - 1);
					end
				end
				B_WAIT: begin
					if (fall) begin
						if (bcnt == '0) begin
							bst <= B_TIDLE;
						end else begin
							bcnt <= bcnt - 1'b1;
						end
					end
				end
				B_TIDLE: begin
					if (fall) begin
						bst <= B_RUN;
						bus_go <= 1'b1;
						bus_refresh <= ref_pend;
					end
				end
				B_RUN: begin
					// ready, waits and chip selects stay with the bus unit
					if (bus_done_i) begin
						bst <= B_TAIL;
						bcnt <= BUS_CNT_W'(OUT_CLK_DIV - 1);
					end
				end
				B_TAIL: begin
					// counted in system cycles so the T-state stays full whatever the done phase
					if (bcnt == '0) begin
						if (in_idle && (ref_pend || pin_lvl[PIN_DMA])) begin
							bst <= B_TIDLE;
						end else begin
							bst <= B_OFF;
						end
					end else begin
						bcnt <= bcnt - 1'b1;
					end
				end
				default: bst <= B_OFF;
			endcase
		end
	end
	assign bus_o.go = bus_go;
	assign bus_o.refresh = bus_refresh;

	// hold handshake; each step waits for a clock output fall
	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			hst <= H_OFF;
		end else if (mode == IPCG_PDOWN) begin
			hst <= H_OFF;
		end else if (fall) begin
			unique case (hst)
				H_OFF: if (pin_lvl[PIN_HOLD]) hst <= H_WAIT;
				H_WAIT: hst <= H_CORE;
				H_CORE: hst <= H_GRANT;
				H_GRANT: if (!pin_lvl[PIN_HOLD]) hst <= H_REL;
				H_REL: hst <= H_OFF;
				default: hst <= H_OFF;
			endcase
		end
	end

	// grant is withdrawn while a refresh waits, as in active mode
	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			bus_grant_out_o <= 1'b0;
		end else begin
			bus_grant_out_o <= (hst == H_GRANT || (hst == H_CORE && fall)) && !ref_pend
				&& !(hst == H_GRANT && fall && !pin_lvl[PIN_HOLD]);
		end
	end

	// one OR of every wake source keeps overlaps glitch free
	always_comb begin
		unique case (mode)
			IPCG_ACTIVE: core_en = 1'b1;
			IPCG_IDLE: core_en = (bst != B_OFF && bst != B_WAIT) || wake_now
				|| hst == H_CORE || hst == H_GRANT || hst == H_REL;
			// restart out of powerdown follows the idle timing
			IPCG_PDOWN: core_en = wake_now;
			default: core_en = 1'b0;
		endcase
	end

	assign clk_en_o.core = core_en;
	assign clk_en_o.periph = (mode != IPCG_PDOWN);
	assign clk_en_o.osc = (mode != IPCG_PDOWN);
	assign sys_clock_out_o = phase;
	assign power_control_reg_o = power_control_reg;
	assign mode_o = mode;

	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (rst_i);

	sequence s_int_wake;
		int_resolved_i && in_idle && wst == W_OFF && !nmi_rise;
	endsequence
	sequence s_int_restart;
		!core_en [*2] ##1 core_en;
	endsequence

	a_int_restart_time: assert property (s_int_wake |=> s_int_restart)
		else $error("core clock not restarted 1.5 clocks after interrupt");
	a_int_vector_time: assert property (s_int_wake |-> ##15 vector_start_o)
		else $error("vectoring not six clocks after restart");
	a_nmi_restart_time: assert property (
		(nmi_rise && in_idle && wst == W_OFF) |-> ##4 core_en ##12 (vector_start_o && vector_nmi_o))
		else $error("nmi restart or vector timing wrong");
	a_wake_keeps_reg: assert property (
		(wst != W_OFF && !pwr_wr_i) |=> power_control_reg == $past(power_control_reg))
		else $error("wake altered power control setting");
	a_reset_clears: assert property (@(posedge clk_sys_i)
		$past(rst_i) |-> (power_control_reg == PWR_RESET && mode == IPCG_ACTIVE))
		else $error("reset did not clear power control");
	a_mode_decode: assert property (
		(halt_i && mode == IPCG_ACTIVE && !wake_now) |=>
		mode == ((power_control_reg == PWR_IDLE) ? IPCG_IDLE :
		(power_control_reg == PWR_PDOWN) ? IPCG_PDOWN : IPCG_ACTIVE))
		else $error("halt selected wrong mode");
	a_pdown_frozen: assert property (
		mode == IPCG_PDOWN |=> (!clk_en_o.periph && !clk_en_o.osc && sys_clock_out_o
		&& !bus_grant_out_o) || mode != IPCG_PDOWN)
		else $error("powerdown clocks not frozen");
	a_grant_refresh: assert property (
		(ref_pend && $past(ref_pend)) |-> !bus_grant_out_o)
		else $error("grant held while refresh pending");
	a_grant_after_core: assert property (
		(in_idle && $rose(bus_grant_out_o)) |-> $past(core_en, 2))
		else $error("grant came before core clock");
	a_idle_tail: assert property (
		(in_idle && bst == B_RUN && bus_done_i) |=> core_en [*2])
		else $error("core clock stopped without idle T-state");
	a_idle_sys_clock_out: assert property (
		in_idle |=> sys_clock_out_o != $past(sys_clock_out_o) || !in_idle)
		else $error("clock output stopped in idle");
	a_pdown_core_off: assert property (
		(mode == IPCG_PDOWN && !wake_now) |-> !core_en)
		else $error("core clock running in powerdown");
	a_hold_restart: assert property (
		(in_idle && hst == H_OFF && fall && pin_lvl[PIN_HOLD]) |-> ##3 core_en)
		else $error("core clock late after hold request");
endmodule
`default_nettype wire

/* bench/ipcg_hold_master.sv */
`default_nettype none
module ipcg_hold_master (
	input wire logic clk_sys_i,
	input wire logic start_i,
	input wire logic [7:0] hold_len_i,
	input wire logic grant_i,
	output logic hold_o
);
	timeunit 1ns;
	timeprecision 1ps;
	int n;
	// hold_len_i sets a quick or a slow master; request kept until granted or 64 cycles pass, then hold_len_i cycles more
	initial begin
		hold_o = 1'b0;
		forever begin
			// start sampled on the rising edge, clear of the bench's falling-edge writes
			@(posedge clk_sys_i);
			if (start_i) begin
				@(negedge clk_sys_i);
				hold_o = 1'b1;
				n = 0;
				while (grant_i !== 1'b1 && n < 64) begin
					@(posedge clk_sys_i);
					n++;
				end
				repeat (hold_len_i) @(posedge clk_sys_i);
				@(negedge clk_sys_i);
				hold_o = 1'b0;
			end
		end
	end
endmodule
`default_nettype wire

/* bench/idle_powerdown_core_clock_gate_tb.sv */
`default_nettype none
module idle_powerdown_core_clock_gate_tb;
	timeunit 1ns;
	timeprecision 1ps;
	import ipcg_pkg::*;
	logic clk_sys_i = 1'b0, rst_i = 1'b1, pwr_wr_i = 1'b0, halt_i = 1'b0;
	logic refresh_zero_i = 1'b0, dma_req_i = 1'b0, nmi_i = 1'b0;
	logic int_resolved_i = 1'b0, bus_done_i = 1'b0, m_start = 1'b0, hold_i;
	logic [PWR_W-1:0] pwr_data_i = '0;
	logic [7:0] m_len = 8'h04;
	ipcg_clk_s clk_en_o;
	ipcg_bus_s bus_o;
	ipcg_mode_e mode_o;
	logic sys_clock_out_o, bus_grant_out_o, vector_start_o, vector_nmi_o;
	logic [PWR_W-1:0] power_control_reg_o;
	int n_fail = 0, checks = 0, n;

	ipcg_gate u_dut (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .pwr_wr_i(pwr_wr_i),
		.pwr_data_i(pwr_data_i), .halt_i(halt_i), .refresh_zero_i(refresh_zero_i),
		.dma_req_i(dma_req_i), .hold_i(hold_i), .nmi_i(nmi_i),
		.int_resolved_i(int_resolved_i), .bus_done_i(bus_done_i), .clk_en_o(clk_en_o),
		.sys_clock_out_o(sys_clock_out_o), .bus_grant_out_o(bus_grant_out_o),
		.bus_o(bus_o), .vector_start_o(vector_start_o), .vector_nmi_o(vector_nmi_o),
		.power_control_reg_o(power_control_reg_o), .mode_o(mode_o));
	ipcg_hold_master u_master (.clk_sys_i(clk_sys_i), .start_i(m_start),
		.hold_len_i(m_len), .grant_i(bus_grant_out_o), .hold_o(hold_i));

	initial forever #2.5 clk_sys_i = ~clk_sys_i;

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			n_fail++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic cyc(input int k);
		repeat (k) @(negedge clk_sys_i);
	endtask
	task automatic pulse(ref logic s);
		s = 1'b1;
		cyc(1);
		s = 1'b0;
	endtask
	function automatic logic pick(input int w);
		case (w)
			0: return clk_en_o.core;
			1: return vector_start_o;
			2: return bus_o.go;
			3: return bus_grant_out_o;
			5: return ~bus_grant_out_o;
			default: return ~clk_en_o.core;
		endcase
	endfunction
	// counts falling edges until the picked output is high; capped so a hang shows
	task automatic wait_hi(input int w, output int k);
		k = 0;
		while (pick(w) !== 1'b1 && k < 300) begin
			cyc(1);
			k++;
		end
		check(k < 300, 1);
	endtask
	task automatic enter(input logic [1:0] m);
		pwr_data_i = m;
		pulse(pwr_wr_i);
		pulse(halt_i);
		cyc(1);
	endtask
	task automatic reset_state();
		check(power_control_reg_o, PWR_RESET);
		check(mode_o, IPCG_ACTIVE);
		check(clk_en_o, 3'h7);
		check(bus_grant_out_o, 0);
	endtask
	task automatic close_out();
		$display("checks=%0d n_fail=%0d", checks, n_fail);
		if (n_fail == 0 && checks > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask

	initial begin
		#(20000 * 5);
		n_fail++;
		close_out();
	end

	initial begin
		void'($urandom(38795));
		cyc(20);
		rst_i = 1'b0;
		cyc(1);
		reset_state();
		for (int m = 0; m < 4; m++) begin
			enter(m[1:0]);
			check(power_control_reg_o, m);
			check(mode_o, (m == 1) ? IPCG_PDOWN : (m == 2) ? IPCG_IDLE : IPCG_ACTIVE);
			check(clk_en_o.core, m == 0 || m == 3);
			check({clk_en_o.periph, clk_en_o.osc}, (m == 1) ? 2'h0 : 2'h3);
			if (m == 1) begin
				pulse(m_start);
				repeat (70) begin
					check(sys_clock_out_o, 1);
					check(bus_grant_out_o, 0);
					cyc(1);
				end
			end
			if (m == 1 || m == 2) begin
				cyc($urandom_range(2, 30));
				pulse(int_resolved_i);
				wait_hi(0, n);
				check(n, INT_RESTART_CYC - 1);
				wait_hi(1, n);
				check(n, VECTOR_CYC);
				check(mode_o, IPCG_ACTIVE);
				check(power_control_reg_o, m);
				check(vector_nmi_o, 0);
			end
			$display("test mode %0d done", m);
		end
		enter(PWR_IDLE);
		cyc($urandom_range(2, 30));
		nmi_i = 1'b1;
		wait_hi(0, n);
		// pin synchroniser and edge detect come before the restart count
		check(n, PIN_SYNC_STAGES + 1 + NMI_RESTART_CYC);
		wait_hi(1, n);
		check(n, VECTOR_CYC);
		check(vector_nmi_o, 1);
		check(power_control_reg_o, PWR_IDLE);
		nmi_i = 1'b0;
		$display("test nmi done");
		enter(PWR_IDLE);
		pulse(refresh_zero_i);
		wait_hi(0, n);
		check(n <= OUT_CLK_DIV, 1);
		wait_hi(2, n);
		check(n, OUT_CLK_DIV);
		check(bus_o.refresh, 1);
		cyc($urandom_range(1, 6));
		pulse(bus_done_i);
		check(clk_en_o.core, 1);
		wait_hi(4, n);
		check(n <= OUT_CLK_DIV, 1);
		check(mode_o, IPCG_IDLE);
		$display("test refresh done");
		dma_req_i = 1'b1;
		wait_hi(2, n);
		check(bus_o.refresh, 0);
		cyc(1);
		pulse(refresh_zero_i);
		pulse(bus_done_i);
		wait_hi(2, n);
		check(bus_o.refresh, 1);
		dma_req_i = 1'b0;
		cyc(8);
		pulse(bus_done_i);
		wait_hi(4, n);
		$display("test dma done");
		m_len = 8'($urandom_range(20, 40));
		pulse(m_start);
		wait_hi(3, n);
		check(clk_en_o.core, 1);
		pulse(refresh_zero_i);
		wait_hi(5, n);
		check(n <= 4, 1);
		wait_hi(2, n);
		check(bus_o.refresh, 1);
		pulse(bus_done_i);
		wait_hi(4, n);
		check(bus_grant_out_o, 0);
		check(hold_i, 0);
		$display("test hold done");
		rst_i = 1'b1;
		cyc(2);
		rst_i = 1'b0;
		cyc(1);
		reset_state();
		$display("test reset done");
		close_out();
	end
endmodule
`default_nettype wire
